// *** logic/bsr_pkg.sv ***
// shared constants and carriers for the shift and rotate unit
package bsr_pkg;

   localparam int unsigned BSR_WORD_W = 16;
   localparam int unsigned BSR_TBL_MAX = 64;
   localparam int unsigned BSR_CNT_W = 5;
   localparam logic [BSR_CNT_W-1:0] BSR_CNT_MIN = 5'h01;
   localparam logic [BSR_CNT_W-1:0] BSR_CNT_MAX = 5'h10;
   localparam logic [BSR_WORD_W-1:0] BSR_WORD_RST = 16'h0000;

   // rotate operation select, one-hot
   typedef enum logic [3:0] {
      BSR_ROT_NONE = 4'h1,
      BSR_ROT_RIGHT_ONE = 4'h2,
      BSR_ROT_LEFT_ONE = 4'h4,
      BSR_ROT_RIGHT_MULTI = 4'h8
   } bsr_rot_op_e;

   // bidirectional shift register controls
   typedef struct packed {
      logic enable;
      logic shift;
      logic dir_left;
      logic data;
   } bsr_sr_ctrl_s;

   // rotate request
   typedef struct packed {
      logic run;
      bsr_rot_op_e op;
      logic [BSR_WORD_W-1:0] src;
      logic [BSR_CNT_W-1:0] cnt;
   } bsr_rot_req_s;

endpackage : bsr_pkg

// *** logic/bsr_unit.sv ***
// shift register and rotate datapath with shared carry flag
// Function
// RULE_01 - enable and shift on: table moves exactly one position
// RULE_02 - direction off: shift toward lower bit addresses
// RULE_03 - direction on: shift toward upper bit addresses
// RULE_04 - data enters top bit on right shift, lowest bit on left
// RULE_05 - bit dropped out of the table goes to carry flag; a rotate executing in the same scan sets carry instead
// RULE_06 - enable off clears table and carry, output held off; a rotate executing in the same scan still sets carry
// RULE_07 - output lowest bit after right shift, else highest; carry kept idle
// RULE_08 - shift repeats every scan while shift input stays on
// RULE_09 - program should pulse shift input for one scan per event
// RULE_10 - one-bit right rotate: bit0 into msb and carry, output lsb
// RULE_11 - one-bit left rotate: msb into lsb and carry, output msb
// RULE_12 - multi rotate right by 1 to 16 into destination, output lsb
// RULE_13 - rotate runs only while input on; else output off, carry kept
// RULE_14 - words are 16 bits; multi rotate carry equals result msb
// RULE_15 - table length fixed per instance; table and carry cleared at reset
`timescale 1ns/1ps
module bsr_unit
   import bsr_pkg::*;
#(
   parameter int unsigned TBL_LEN = BSR_TBL_MAX
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire bsr_sr_ctrl_s i_sr_ctrl,
   input wire bsr_rot_req_s i_rot_req,
   output logic [TBL_LEN-1:0] o_sr_table,
   output logic o_sr_out,
   output logic o_carry_flag,
   output logic [BSR_WORD_W-1:0] o_rot_result,
   output logic o_rot_valid,
   output logic o_rot_out
);

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [TBL_LEN-1:0] tbl_reg;
   logic [TBL_LEN-1:0] tbl_next;
   logic sr_out_reg;
   logic sr_out_next;
   logic cf_reg;
   logic cf_next;
   logic [BSR_WORD_W-1:0] rot_res_reg;
   logic [BSR_WORD_W-1:0] rot_res_next;
   logic rot_valid_reg;
   logic rot_valid_next;
   logic rot_out_reg;
   logic rot_out_next;
   logic rot_exec;
   logic cnt_ok;
   logic [TBL_LEN:0] shl_wide;
   logic [TBL_LEN:0] shr_wide;
   logic [2*BSR_WORD_W-1:0] rot_wide;

   assign shl_wide = {tbl_reg, i_sr_ctrl.data};
   assign shr_wide = {i_sr_ctrl.data, tbl_reg};
   assign rot_wide = {i_rot_req.src, i_rot_req.src} >> i_rot_req.cnt;
   assign cnt_ok = (i_rot_req.cnt >= BSR_CNT_MIN) && (i_rot_req.cnt <= BSR_CNT_MAX);

   ////////////////////////////////////////////////////////////////////////
   // shift register next state
   always_comb
   begin
      tbl_next = tbl_reg;
      sr_out_next = 1'b0;
      if (!i_sr_ctrl.enable)
      begin
         // RULE_06 clear on disable
         tbl_next = '0;
         sr_out_next = 1'b0;
      end
      else if (i_sr_ctrl.shift)
      begin
         // RULE_01 one position move
         // RULE_08 every scan
         if (i_sr_ctrl.dir_left)
         begin
            // RULE_03 left shift
            // RULE_04 data into lowest
            tbl_next = shl_wide[TBL_LEN-1:0];
            // RULE_07 output highest bit
            sr_out_next = shl_wide[TBL_LEN-1];
         end
         else
         begin
            // RULE_02 right shift
            // RULE_04 data into top
            tbl_next = shr_wide[TBL_LEN:1];
            // RULE_07 output lowest bit
            sr_out_next = shr_wide[1];
         end
      end
      else
      begin
         // RULE_07 idle shows highest
         sr_out_next = tbl_reg[TBL_LEN-1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // rotate and carry next state
   always_comb
   begin
      rot_res_next = rot_res_reg;
      rot_valid_next = 1'b0;
      rot_out_next = 1'b0;
      rot_exec = 1'b0;
      cf_next = cf_reg;
      if (!i_sr_ctrl.enable)
      begin
         cf_next = 1'b0;
      end
      else if (i_sr_ctrl.shift)
      begin
         // RULE_05 dropped bit to carry
         cf_next = i_sr_ctrl.dir_left ? tbl_reg[TBL_LEN-1] : tbl_reg[0];
      end
      // RULE_13 rotate only while on
      if (i_rot_req.run)
      begin
         case (i_rot_req.op)
            BSR_ROT_RIGHT_ONE:
            begin
               // RULE_10 right by one
               rot_exec = 1'b1;
               rot_res_next = {i_rot_req.src[0], i_rot_req.src[BSR_WORD_W-1:1]};
               cf_next = i_rot_req.src[0];
               rot_out_next = i_rot_req.src[1];
            end
            BSR_ROT_LEFT_ONE:
            begin
               // RULE_11 left by one
               rot_exec = 1'b1;
               rot_res_next = {i_rot_req.src[BSR_WORD_W-2:0], i_rot_req.src[BSR_WORD_W-1]};
               cf_next = i_rot_req.src[BSR_WORD_W-1];
               rot_out_next = i_rot_req.src[BSR_WORD_W-2];
            end
            BSR_ROT_RIGHT_MULTI:
            begin
               if (cnt_ok)
               begin
                  // RULE_12 right by count
                  rot_exec = 1'b1;
                  rot_res_next = rot_wide[BSR_WORD_W-1:0];
                  rot_out_next = rot_wide[0];
                  // RULE_14 carry is result msb
                  cf_next = rot_wide[BSR_WORD_W-1];
               end
            end
            default:
            begin
               rot_exec = 1'b0;
            end
         endcase
         rot_valid_next = rot_exec;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   // RULE_15 reset clears table
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         tbl_reg <= '0;
         sr_out_reg <= 1'b0;
         cf_reg <= 1'b0;
         rot_res_reg <= BSR_WORD_RST;
         rot_valid_reg <= 1'b0;
         rot_out_reg <= 1'b0;
      end
      else
      begin
         tbl_reg <= tbl_next;
         sr_out_reg <= sr_out_next;
         cf_reg <= cf_next;
         rot_res_reg <= rot_res_next;
         rot_valid_reg <= rot_valid_next;
         rot_out_reg <= rot_out_next;
      end
   end

   assign o_sr_table = tbl_reg;
   assign o_sr_out = sr_out_reg;
   assign o_carry_flag = cf_reg;
   assign o_rot_result = rot_res_reg;
   assign o_rot_valid = rot_valid_reg;
   assign o_rot_out = rot_out_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks
   sr_clear_a : assert property ( // RULE_06
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!i_sr_ctrl.enable && !rot_exec) |=> (o_sr_table == '0) && !o_carry_flag && !o_sr_out)
      else $error("table or carry not cleared");

   shl_data_a : assert property ( // RULE_04
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_sr_ctrl.enable && i_sr_ctrl.shift && i_sr_ctrl.dir_left)
      |=> (o_sr_table[0] == $past(i_sr_ctrl.data)) && (o_sr_out == o_sr_table[TBL_LEN-1]))
      else $error("left shift data or output wrong");

   shr_data_a : assert property ( // RULE_04
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_sr_ctrl.enable && i_sr_ctrl.shift && !i_sr_ctrl.dir_left)
      |=> (o_sr_table[TBL_LEN-1] == $past(i_sr_ctrl.data)) && (o_sr_out == o_sr_table[0]))
      else $error("right shift data or output wrong");

   shl_carry_a : assert property ( // RULE_05
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_sr_ctrl.enable && i_sr_ctrl.shift && i_sr_ctrl.dir_left && !rot_exec)
      |=> o_carry_flag == $past(o_sr_table[TBL_LEN-1]))
      else $error("left shift carry wrong");

   shr_carry_a : assert property ( // RULE_05
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_sr_ctrl.enable && i_sr_ctrl.shift && !i_sr_ctrl.dir_left && !rot_exec)
      |=> o_carry_flag == $past(o_sr_table[0]))
      else $error("right shift carry wrong");

   shl_move_a : assert property ( // RULE_03
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_sr_ctrl.enable && i_sr_ctrl.shift && i_sr_ctrl.dir_left)
      |=> o_sr_table == (($past(o_sr_table) << 1) | TBL_LEN'($past(i_sr_ctrl.data))))
      else $error("left shift did not move one position");

   shr_move_a : assert property ( // RULE_02
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_sr_ctrl.enable && i_sr_ctrl.shift && !i_sr_ctrl.dir_left)
      |=> o_sr_table == (($past(o_sr_table) >> 1) | (TBL_LEN'($past(i_sr_ctrl.data)) << (TBL_LEN - 1))))
      else $error("right shift did not move one position");

   sr_off_a : assert property ( // RULE_06
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      !i_sr_ctrl.enable
      |=> (o_sr_table == '0) && !o_sr_out)
      else $error("table or output not off while disabled");

   sr_hold_a : assert property ( // RULE_07
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_sr_ctrl.enable && !i_sr_ctrl.shift && !rot_exec)
      |=> $stable(o_sr_table) && $stable(o_carry_flag) && (o_sr_out == o_sr_table[TBL_LEN-1]))
      else $error("idle table not held");

   ////////////////////////////////////////////////////////////////////////
   // rotate checks
   rot_right_a : assert property ( // RULE_10
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_rot_req.run && i_rot_req.op == BSR_ROT_RIGHT_ONE)
      |=> (o_rot_result == {$past(i_rot_req.src[0]), $past(i_rot_req.src[BSR_WORD_W-1:1])})
      && (o_carry_flag == o_rot_result[BSR_WORD_W-1]) && (o_rot_out == o_rot_result[0]))
      else $error("one-bit right rotate wrong");

   rot_left_a : assert property ( // RULE_11
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_rot_req.run && i_rot_req.op == BSR_ROT_LEFT_ONE)
      |=> (o_rot_result == {$past(i_rot_req.src[BSR_WORD_W-2:0]), $past(i_rot_req.src[BSR_WORD_W-1])})
      && (o_carry_flag == o_rot_result[0]) && (o_rot_out == o_rot_result[BSR_WORD_W-1]))
      else $error("one-bit left rotate wrong");

   rot_multi_a : assert property ( // RULE_12
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_rot_req.run && i_rot_req.op == BSR_ROT_RIGHT_MULTI && cnt_ok)
      |=> o_rot_valid && (o_rot_out == o_rot_result[0])
      && (o_carry_flag == o_rot_result[BSR_WORD_W-1]))
      else $error("multi rotate output or carry wrong");

   rot_idle_a : assert property ( // RULE_13
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      !i_rot_req.run |=> !o_rot_out && !o_rot_valid && $stable(o_rot_result))
      else $error("rotate acted while input off");

   rot_exec_a : assert property ( // RULE_13
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_rot_req.run && (i_rot_req.op == BSR_ROT_RIGHT_ONE || i_rot_req.op == BSR_ROT_LEFT_ONE))
      |=> o_rot_valid)
      else $error("one-bit rotate not executed");

   rot_count_a : assert property ( // RULE_12
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_rot_req.run && i_rot_req.op == BSR_ROT_RIGHT_MULTI && !cnt_ok)
      |=> !o_rot_valid && !o_rot_out && $stable(o_rot_result))
      else $error("rotate ran with count out of range");

   rot_stray_a : assert property ( // RULE_13
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_rot_req.run && i_rot_req.op != BSR_ROT_RIGHT_ONE && i_rot_req.op != BSR_ROT_LEFT_ONE
      && i_rot_req.op != BSR_ROT_RIGHT_MULTI)
      |=> !o_rot_valid && !o_rot_out && $stable(o_rot_result))
      else $error("rotate ran on unknown operation");

   rot_carry_keep_a : assert property ( // RULE_13
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!i_rot_req.run && i_sr_ctrl.enable && !i_sr_ctrl.shift)
      |=> $stable(o_carry_flag))
      else $error("carry changed with nothing running");

   rot_value_a : assert property ( // RULE_12
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_rot_req.run && i_rot_req.op == BSR_ROT_RIGHT_MULTI && cnt_ok)
      |=> ((({o_rot_result, o_rot_result} << $past(i_rot_req.cnt)) >> BSR_WORD_W)
      == {{BSR_WORD_W{1'b0}}, $past(i_rot_req.src)}))
      else $error("multi rotate result wrong");

   rot_clear_carry_a : assert property ( // RULE_11
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_rot_req.run && i_rot_req.op == BSR_ROT_LEFT_ONE && !i_sr_ctrl.enable)
      |=> o_carry_flag == $past(i_rot_req.src[BSR_WORD_W-1]))
      else $error("rotate carry lost to table clear");

endmodule : bsr_unit

// *** test/test_bsr_unit.sv ***
// self-checking bench for the shift and rotate unit
`timescale 1ns/1ps
module test_bsr_unit;
   import bsr_pkg::*;
   localparam int unsigned L = 9;
   localparam bsr_rot_req_s rq_idle = '{1'b0, BSR_ROT_NONE, 16'h0000, 5'h00};
   logic i_sys_clk = 1'b0;
   logic i_rst_b = 1'b0;
   bsr_sr_ctrl_s i_sr_ctrl = '0;
   bsr_rot_req_s i_rot_req = rq_idle;
   logic [L-1:0] o_sr_table;
   logic o_sr_out;
   logic o_carry_flag;
   logic [BSR_WORD_W-1:0] o_rot_result;
   logic o_rot_valid;
   logic o_rot_out;
   logic [L-1:0] m_tbl = '0;
   logic [15:0] m_res = 16'h0000;
   logic m_cy = 1'b0;
   logic m_so = 1'b0;
   logic m_rv = 1'b0;
   logic m_ro = 1'b0;
   int err_count = 0;
   int checks = 0;

   always #25 i_sys_clk = ~i_sys_clk;

   bsr_unit #(.TBL_LEN(L)) i_bsr_unit (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_sr_ctrl(i_sr_ctrl),
      .i_rot_req(i_rot_req),
      .o_sr_table(o_sr_table),
      .o_sr_out(o_sr_out),
      .o_carry_flag(o_carry_flag),
      .o_rot_result(o_rot_result),
      .o_rot_valid(o_rot_valid),
      .o_rot_out(o_rot_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp_tbl(input logic [L-1:0] got, input logic [L-1:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t table got %h exp %h", $time, got, exp);
      end
   endtask : cmp_tbl

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t result got %h exp %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_bit(input logic got, input logic exp, input string what);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask : cmp_bit

   task automatic chk;
      cmp_tbl(o_sr_table, m_tbl);
      cmp_bit(o_sr_out, m_so, "shift out");
      cmp_bit(o_carry_flag, m_cy, "carry");
      cmp_word(o_rot_result, m_res);
      cmp_bit(o_rot_valid, m_rv, "valid");
      cmp_bit(o_rot_out, m_ro, "rotate out");
   endtask : chk

   ////////////////////////////////////////////////////////////////////////////////
   // one scan: drive, predict, check one cycle later
   task automatic step(input bsr_sr_ctrl_s s, input bsr_rot_req_s r);
      logic [31:0] dbl;
      logic ex;
      i_sr_ctrl = s;
      i_rot_req = r;
      m_rv = 1'b0;
      m_ro = 1'b0;
      if (!s.enable)
      begin
         m_tbl = '0;
         m_cy = 1'b0;
      end
      else if (s.shift && s.dir_left)
      begin
         m_cy = m_tbl[L-1];
         m_tbl = {m_tbl[L-2:0], s.data};
      end
      else if (s.shift)
      begin
         m_cy = m_tbl[0];
         m_tbl = {s.data, m_tbl[L-1:1]};
      end
      m_so = (s.enable && s.shift && !s.dir_left) ? m_tbl[0] : m_tbl[L-1];
      ex = r.run && (r.op == BSR_ROT_RIGHT_ONE || r.op == BSR_ROT_LEFT_ONE ||
         (r.op == BSR_ROT_RIGHT_MULTI && r.cnt >= BSR_CNT_MIN && r.cnt <= BSR_CNT_MAX));
      dbl = {r.src, r.src} >> ((r.op == BSR_ROT_RIGHT_MULTI) ? r.cnt : 5'h01);
      if (ex)
      begin
         m_res = (r.op == BSR_ROT_LEFT_ONE) ? {r.src[14:0], r.src[15]} : dbl[15:0];
         m_cy = (r.op == BSR_ROT_LEFT_ONE) ? r.src[15] : m_res[15];
         m_ro = (r.op == BSR_ROT_LEFT_ONE) ? m_res[15] : m_res[0];
         m_rv = 1'b1;
      end
      @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      chk();
   endtask : step

   task automatic sr(input logic en, input logic sh, input logic dl, input logic d);
      step(bsr_sr_ctrl_s'{en, sh, dl, d}, rq_idle);
   endtask : sr

   task automatic rot(input logic run, input bsr_rot_op_e op, input logic [15:0] src, input logic [4:0] cnt);
      step(bsr_sr_ctrl_s'{1'b1, 1'b0, 1'b0, 1'b0}, bsr_rot_req_s'{run, op, src, cnt});
   endtask : rot

   task automatic reset_pulse;
      i_rst_b = 1'b0;
      m_tbl = '0;
      m_res = BSR_WORD_RST;
      m_cy = 1'b0;
      m_so = 1'b0;
      m_rv = 1'b0;
      m_ro = 1'b0;
      @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      chk();
      i_rst_b = 1'b1;
   endtask : reset_pulse

   task automatic complete_run;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(negedge i_sys_clk);
      i_rst_b = 1'b1;
      chk();
      sr(1'b1, 1'b0, 1'b0, 1'b0);
      $display("test reset done");
      for (int k = 0; k < 12; k++) sr(1'b1, 1'b1, 1'b1, k[0] ^ k[2]);
      for (int k = 0; k < 12; k++) sr(1'b1, 1'b1, 1'b0, k[1]);
      sr(1'b1, 1'b0, 1'b0, 1'b1);
      sr(1'b1, 1'b0, 1'b1, 1'b0);
      $display("test shift done");
      rot(1'b1, BSR_ROT_RIGHT_ONE, 16'h0001, 5'h00);
      rot(1'b1, BSR_ROT_RIGHT_ONE, 16'h8002, 5'h00);
      rot(1'b1, BSR_ROT_LEFT_ONE, 16'h8000, 5'h00);
      rot(1'b1, BSR_ROT_LEFT_ONE, 16'h4001, 5'h00);
      for (int c = 1; c <= 16; c++) rot(1'b1, BSR_ROT_RIGHT_MULTI, 16'hb4c3, c[4:0]);
      $display("test rotate done");
      rot(1'b0, BSR_ROT_RIGHT_ONE, 16'h0002, 5'h00);
      rot(1'b1, BSR_ROT_NONE, 16'h0002, 5'h00);
      rot(1'b1, BSR_ROT_RIGHT_MULTI, 16'h0002, 5'h00);
      rot(1'b1, BSR_ROT_RIGHT_MULTI, 16'h0002, 5'h11);
      rot(1'b1, bsr_rot_op_e'(4'h6), 16'h0002, 5'h01);
      $display("test refused done");
      rot(1'b1, BSR_ROT_RIGHT_ONE, 16'h0001, 5'h00);
      sr(1'b0, 1'b1, 1'b1, 1'b1);
      sr(1'b0, 1'b0, 1'b0, 1'b1);
      step(bsr_sr_ctrl_s'{1'b0, 1'b0, 1'b0, 1'b0}, bsr_rot_req_s'{1'b1, BSR_ROT_LEFT_ONE, 16'h8000, 5'h00});
      $display("test clear done");
      for (int k = 0; k < 6; k++) sr(1'b1, k[0], 1'b1, 1'b1);
      step(bsr_sr_ctrl_s'{1'b1, 1'b1, 1'b1, 1'b0}, bsr_rot_req_s'{1'b1, BSR_ROT_RIGHT_ONE, 16'h0003, 5'h00});
      $display("test pulse done");
      reset_pulse();
      sr(1'b1, 1'b0, 1'b0, 1'b0);
      $display("test mid reset done");
      complete_run();
   end

   initial
   begin
      repeat (5000) @(posedge i_sys_clk);
      err_count++;
      $display("ERROR %0t run did not finish", $time);
      complete_run();
   end
endmodule : test_bsr_unit
